// ==== inc/led_tpg_pkg.sv ====
// constants, field layouts and carriers for the led and test packet register bank
package led_tpg_pkg;

  // management register addresses
  localparam logic [4:0] REG_LED = 5'h1b;
  localparam logic [4:0] REG_GEN = 5'h1c;
  localparam logic [4:0] REG_PAY = 5'h1d;

  // reset values
  localparam logic [15:0] LED_RST = 16'h0f00;
  localparam logic [15:0] GEN_RST = 16'h0000;
  localparam logic [15:0] PAY_RST = 16'h00aa;

  // writable bits, all others read as zero
  localparam logic [15:0] LED_WMASK = 16'h0f0f;
  localparam logic [15:0] GEN_WMASK = 16'h2f73;
  localparam logic [15:0] PAY_WMASK = 16'hffff;

  // field positions
  localparam int unsigned LED_NUM = 4;
  localparam int unsigned LED_EN_LSB = 8;
  localparam int unsigned LED_DA_LSB = 0;
  localparam int unsigned MODE_BIT = 13;
  localparam int unsigned GAP_LSB = 10;
  localparam int unsigned TYPE_LSB = 8;
  localparam int unsigned SIZE_LSB = 4;
  localparam int unsigned START_BIT = 1;
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned DA_LSB = 12;
  localparam int unsigned SA_LSB = 8;
  localparam int unsigned DATA_LSB = 0;

  // field encodings
  localparam logic MODE_BURST = 1'h0;
  localparam logic MODE_SINGLE = 1'h1;
  localparam logic [1:0] GAP_CODE_SHORT = 2'h0;
  localparam logic [1:0] GAP_CODE_STANDARD = 2'h1;
  localparam logic [1:0] GAP_CODE_LONG = 2'h2;
  localparam logic [1:0] GAP_CODE_LONGEST = 2'h3;
  localparam logic [1:0] TYPE_RANDOM = 2'h0;
  localparam logic [1:0] TYPE_INCREMENTING = 2'h1;
  localparam logic [1:0] TYPE_FIXED = 2'h2;
  localparam logic [1:0] TYPE_UNDEFINED = 2'h3;

  // gap lengths in bit times, frame sizes in bytes
  localparam logic [13:0] GAP_SHORT_BT = 14'h0030;
  localparam logic [13:0] GAP_STANDARD_BT = 14'h0060;
  localparam logic [13:0] SIZE_B64 = 14'h0040;
  localparam logic [13:0] SIZE_B128 = 14'h0080;
  localparam logic [13:0] SIZE_B256 = 14'h0100;
  localparam logic [13:0] SIZE_B512 = 14'h0200;
  localparam logic [13:0] SIZE_B1024 = 14'h0400;
  localparam logic [13:0] SIZE_B1518 = 14'h05ee;
  localparam logic [13:0] SIZE_B9600 = 14'h2580;

  // decoded generator configuration
  typedef struct packed {
    logic enable;
    logic start;
    logic mode;
    logic [1:0] gap;
    logic [1:0] ptype;
    logic [2:0] size;
  } gen_cfg_t;

  // payload and address nibbles
  typedef struct packed {
    logic [3:0] da;
    logic [3:0] sa;
    logic [7:0] data;
  } payload_t;

  // one-hot sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SEND = 3'h2,
    ST_HOLD = 3'h4
  } seq_t;

endpackage

// ==== logic/led_tpg_regs.sv ====
// led override and test packet generator control register bank
`timescale 1ns/10ps
module led_tpg_regs #(
  parameter int unsigned BURST_PKTS = 10000,
  parameter logic [13:0] GAP_LONG_BT = 14'h2580,
  parameter logic [13:0] GAP_LONGEST_BT = 14'h2580
) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  // management register port
  input wire logic [4:0] MGMT_ADDR_I,
  input wire logic MGMT_WR_I,
  input wire logic [15:0] MGMT_WDATA_I,
  input wire logic MGMT_RD_I,
  output logic [15:0] MGMT_RDATA_O,
  output logic MGMT_HIT_O,
  // leds
  input wire logic [3:0] LED_FUNC_I,
  output logic [3:0] LED_O,
  // generator datapath
  output led_tpg_pkg::gen_cfg_t GEN_CFG_O,
  output led_tpg_pkg::payload_t GEN_PAYLOAD_O,
  output logic [13:0] GEN_GAP_BT_O,
  output logic [13:0] GEN_SIZE_BYTES_O,
  output logic PKT_REQ_O,
  input wire logic PKT_DONE_I,
  output logic GEN_BUSY_O,
  output logic [13:0] GEN_BURST_CNT_O
);

  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [15:0] led_r, led_nxt;
  logic [15:0] gen_r, gen_nxt;
  logic [15:0] pay_r, pay_nxt;
  logic [15:0] rdata_r, rdata_nxt;

  always_comb begin
    led_nxt = led_r;
    gen_nxt = gen_r;
    pay_nxt = pay_r;
    if (MGMT_WR_I) begin
      unique case (MGMT_ADDR_I)
        led_tpg_pkg::REG_LED: begin
          led_nxt = MGMT_WDATA_I & led_tpg_pkg::LED_WMASK;
        end
        led_tpg_pkg::REG_GEN: begin
          gen_nxt = MGMT_WDATA_I & led_tpg_pkg::GEN_WMASK;
        end
        led_tpg_pkg::REG_PAY: begin
          pay_nxt = MGMT_WDATA_I & led_tpg_pkg::PAY_WMASK;
        end
        default: begin
          led_nxt = led_r;
        end
      endcase
    end
  end

  // other addresses belong to the rest of the phy, so answer zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (MGMT_RD_I) begin
      unique case (MGMT_ADDR_I)
        led_tpg_pkg::REG_LED: rdata_nxt = led_r;
        led_tpg_pkg::REG_GEN: rdata_nxt = gen_r;
        led_tpg_pkg::REG_PAY: rdata_nxt = pay_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      led_r <= led_tpg_pkg::LED_RST;
      gen_r <= led_tpg_pkg::GEN_RST;
      pay_r <= led_tpg_pkg::PAY_RST;
      rdata_r <= 16'h0000;
    end else begin
      led_r <= led_nxt;
      gen_r <= gen_nxt;
      pay_r <= pay_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign MGMT_RDATA_O = rdata_r;
  assign MGMT_HIT_O = (MGMT_ADDR_I == led_tpg_pkg::REG_LED) ||
                      (MGMT_ADDR_I == led_tpg_pkg::REG_GEN) ||
                      (MGMT_ADDR_I == led_tpg_pkg::REG_PAY);

  ////////////////////////////////////////////////////////////////////////
  // led override
  logic [3:0] led_out_r, led_out_nxt;

  // direct bit only counts while the function is off; both can change in the same write
  for (genvar i = 0; i < led_tpg_pkg::LED_NUM; i++) begin : g_led
    always_comb begin
      led_out_nxt[i] = led_r[led_tpg_pkg::LED_EN_LSB + i] ?
                       LED_FUNC_I[i] : led_r[led_tpg_pkg::LED_DA_LSB + i];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      led_out_r <= 4'h0;
    end else begin
      led_out_r <= led_out_nxt;
    end
  end

  assign LED_O = led_out_r;

  ////////////////////////////////////////////////////////////////////////
  // generator configuration decode
  led_tpg_pkg::gen_cfg_t cfg_r, cfg_nxt;
  logic [13:0] gap_bt_r, gap_bt_nxt;
  logic [13:0] size_b_r, size_b_nxt;
  logic [1:0] raw_type;

  always_comb begin
    raw_type = gen_r[led_tpg_pkg::TYPE_LSB +: 2];
    cfg_nxt.enable = gen_r[led_tpg_pkg::EN_BIT];
    cfg_nxt.start = gen_r[led_tpg_pkg::START_BIT];
    cfg_nxt.mode = gen_r[led_tpg_pkg::MODE_BIT];
    cfg_nxt.gap = gen_r[led_tpg_pkg::GAP_LSB +: 2];
    cfg_nxt.size = gen_r[led_tpg_pkg::SIZE_LSB +: 3];
    // undefined code falls back to random content
    cfg_nxt.ptype = (raw_type == led_tpg_pkg::TYPE_UNDEFINED) ?
                    led_tpg_pkg::TYPE_RANDOM : raw_type;
    unique case (cfg_nxt.gap)
      led_tpg_pkg::GAP_CODE_SHORT: gap_bt_nxt = led_tpg_pkg::GAP_SHORT_BT;
      led_tpg_pkg::GAP_CODE_STANDARD: gap_bt_nxt = led_tpg_pkg::GAP_STANDARD_BT;
      led_tpg_pkg::GAP_CODE_LONG: gap_bt_nxt = GAP_LONG_BT;
      led_tpg_pkg::GAP_CODE_LONGEST: gap_bt_nxt = GAP_LONGEST_BT;
    endcase
    unique case (cfg_nxt.size)
      3'h1: size_b_nxt = led_tpg_pkg::SIZE_B128;
      3'h2: size_b_nxt = led_tpg_pkg::SIZE_B256;
      3'h3: size_b_nxt = led_tpg_pkg::SIZE_B512;
      3'h4: size_b_nxt = led_tpg_pkg::SIZE_B1024;
      3'h5: size_b_nxt = led_tpg_pkg::SIZE_B1518;
      3'h6: size_b_nxt = led_tpg_pkg::SIZE_B9600;
      default: size_b_nxt = led_tpg_pkg::SIZE_B64;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cfg_r <= '0;
      gap_bt_r <= led_tpg_pkg::GAP_SHORT_BT;
      size_b_r <= led_tpg_pkg::SIZE_B64;
    end else begin
      cfg_r <= cfg_nxt;
      gap_bt_r <= gap_bt_nxt;
      size_b_r <= size_b_nxt;
    end
  end

  assign GEN_CFG_O = cfg_r;
  assign GEN_GAP_BT_O = gap_bt_r;
  assign GEN_SIZE_BYTES_O = size_b_r;
  assign GEN_PAYLOAD_O = led_tpg_pkg::payload_t'(pay_r);

  ////////////////////////////////////////////////////////////////////////
  // packet sequencer
  led_tpg_pkg::seq_t st_r, st_nxt;
  logic [13:0] cnt_r, cnt_nxt;
  logic run;

  // single mode holds until start or enable is cleared, so a fresh start is a new packet
  always_comb begin
    run = cfg_r.enable && cfg_r.start;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      led_tpg_pkg::ST_IDLE: begin
        cnt_nxt = 14'h0000;
        if (run) begin
          st_nxt = led_tpg_pkg::ST_SEND;
        end
      end
      led_tpg_pkg::ST_SEND: begin
        if (!run) begin
          st_nxt = led_tpg_pkg::ST_IDLE;
        end else if (PKT_DONE_I) begin
          if (cfg_r.mode == led_tpg_pkg::MODE_SINGLE) begin
            st_nxt = led_tpg_pkg::ST_HOLD;
          end else if (cnt_r == 14'(BURST_PKTS - 1)) begin
            cnt_nxt = 14'h0000;
          end else begin
            cnt_nxt = cnt_r + 14'h0001;
          end
        end
      end
      led_tpg_pkg::ST_HOLD: begin
        if (!run) begin
          st_nxt = led_tpg_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = led_tpg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_r <= led_tpg_pkg::ST_IDLE;
      cnt_r <= 14'h0000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign PKT_REQ_O = (st_r == led_tpg_pkg::ST_SEND);
  assign GEN_BUSY_O = (st_r != led_tpg_pkg::ST_IDLE);
  assign GEN_BURST_CNT_O = cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence single_done_s;
    PKT_REQ_O && PKT_DONE_I && run && cfg_r.mode;
  endsequence

  sequence burst_wrap_s;
    PKT_REQ_O && PKT_DONE_I && run && !cfg_r.mode && cnt_r == 14'(BURST_PKTS - 1);
  endsequence

  led_direct_on_a: assert property (
    !led_r[led_tpg_pkg::LED_EN_LSB] && led_r[led_tpg_pkg::LED_DA_LSB] |=> LED_O[0])
    else $error("direct led not lit");
  led_func_path_a: assert property (
    led_r[led_tpg_pkg::LED_EN_LSB + 3] |=> LED_O[3] == $past(LED_FUNC_I[3]))
    else $error("led function not passed");
  led_reserved_a: assert property (
    (led_r & ~led_tpg_pkg::LED_WMASK) == 16'h0000)
    else $error("led reserved bit set");
  gen_reserved_a: assert property (
    (gen_r & ~led_tpg_pkg::GEN_WMASK) == 16'h0000)
    else $error("generator reserved bit set");
  reset_values_a: assert property (
    $rose(RST_B_I) |-> led_r == led_tpg_pkg::LED_RST && gen_r == led_tpg_pkg::GEN_RST)
    else $error("bad reset value");
  single_stop_a: assert property (
    single_done_s |=> !PKT_REQ_O && GEN_BUSY_O)
    else $error("single mode sent more");
  burst_wrap_a: assert property (
    burst_wrap_s |=> PKT_REQ_O && cnt_r == 14'h0000)
    else $error("burst did not continue");
  // gap and size flops load on the same edge as cfg_r, so they line up in one cycle
  gap_short_a: assert property (
    cfg_r.gap == led_tpg_pkg::GAP_CODE_SHORT |-> GEN_GAP_BT_O == 14'h0030)
    else $error("gap code short wrong");
  size_default_a: assert property (
    cfg_r.size == 3'h7 |-> GEN_SIZE_BYTES_O == 14'h0040)
    else $error("undefined size not 64");
  gap_long_a: assert property (
    cfg_r.gap == led_tpg_pkg::GAP_CODE_LONG |-> GEN_GAP_BT_O == GAP_LONG_BT)
    else $error("long gap code wrong");
  size_jumbo_a: assert property (
    cfg_r.size == 3'h6 |-> GEN_SIZE_BYTES_O == 14'h2580)
    else $error("size code six wrong");
  ptype_fold_a: assert property (
    GEN_CFG_O.ptype != led_tpg_pkg::TYPE_UNDEFINED)
    else $error("undefined payload type shown");
  led_dark_a: assert property (
    !led_r[led_tpg_pkg::LED_EN_LSB + 1] && !led_r[led_tpg_pkg::LED_DA_LSB + 1] |=> !LED_O[1])
    else $error("dark led lit");
  gen_readback_a: assert property (
    MGMT_RD_I && MGMT_ADDR_I == led_tpg_pkg::REG_GEN |=> MGMT_RDATA_O == $past(gen_r))
    else $error("generator readback wrong");
  burst_count_a: assert property (
    cnt_r < 14'(BURST_PKTS))
    else $error("burst count out of range");
  gen_disable_a: assert property (
    !cfg_r.enable |=> !PKT_REQ_O)
    else $error("disabled generator requested");
  payload_write_a: assert property (
    MGMT_WR_I && MGMT_ADDR_I == led_tpg_pkg::REG_PAY |=> pay_r == $past(MGMT_WDATA_I))
    else $error("payload write lost");

endmodule // led_tpg_regs

// ==== test/led_tpg_regs_bench.sv ====
// self-checking bench for the led and test packet register bank
`timescale 1ns/10ps
module led_tpg_regs_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] led_func = 4'hf;
  logic done = 1'b0;
  logic wr, rd, hit, req, busy;
  logic [4:0] addr;
  logic [15:0] wdata, rdata;
  logic [3:0] led;
  logic [13:0] gap, size, cnt;
  led_tpg_pkg::gen_cfg_t cfg;
  led_tpg_pkg::payload_t pay;
  int n_fail = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  mgmt_host i_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
    .rd_o(rd));
  led_tpg_regs #(.BURST_PKTS(4)) i_dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .MGMT_ADDR_I(addr),
    .MGMT_WR_I(wr), .MGMT_WDATA_I(wdata), .MGMT_RD_I(rd), .MGMT_RDATA_O(rdata), .MGMT_HIT_O(hit),
    .LED_FUNC_I(led_func), .LED_O(led), .GEN_CFG_O(cfg), .GEN_PAYLOAD_O(pay),
    .GEN_GAP_BT_O(gap), .GEN_SIZE_BYTES_O(size), .PKT_REQ_O(req), .PKT_DONE_I(done),
    .GEN_BUSY_O(busy), .GEN_BURST_CNT_O(cnt));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    i_host.rd_reg(a, d);
    chk("rdata", e, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait; running out counts as a mismatch
  task automatic wait_req(input logic v);
    int k;
    k = 0;
    while (req !== v && k < 20) begin
      cyc(1);
      k++;
    end
    chk("req", {15'h0000, v}, {15'h0000, req});
    if (req !== v) wrap_up();
  endtask
  // datapath reports one finished packet
  task automatic pkt_done();
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    cyc(2);
    chk("led", 16'h000f, {12'h000, led});
    rdchk(5'h1b, 16'h0f00);
    rdchk(5'h1c, 16'h0000);
    rdchk(5'h1d, 16'h00aa);
    chk("hit", 16'h0001, {15'h0000, hit});
    rdchk(5'h05, 16'h0000);
    chk("hit", 16'h0000, {15'h0000, hit});
  endtask
  task automatic t_reserved();
    i_host.wr_reg(5'h1b, 16'hffff);
    rdchk(5'h1b, 16'h0f0f);
    i_host.wr_reg(5'h1c, 16'hdc80);
    rdchk(5'h1c, 16'h0c00);
    i_host.wr_reg(5'h1d, 16'h5a3c);
    cyc(1);
    chk("payload", 16'h5a3c, pay);
  endtask
  task automatic t_led();
    i_host.wr_reg(5'h1b, 16'h0000);
    cyc(2);
    chk("led", 16'h0000, {12'h000, led});
    i_host.wr_reg(5'h1b, 16'h0005);
    cyc(2);
    chk("led", 16'h0005, {12'h000, led});
    @(posedge clk);
    led_func <= 4'h8;
    // direct bit only where the function is already off
    i_host.wr_reg(5'h1b, 16'h0c01);
    cyc(2);
    chk("led", 16'h0009, {12'h000, led});
  endtask
  task automatic t_fields();
    logic [13:0] gx [4];
    logic [13:0] sx [8];
    gx = '{led_tpg_pkg::GAP_SHORT_BT, led_tpg_pkg::GAP_STANDARD_BT, 14'h2580, 14'h2580};
    sx = '{led_tpg_pkg::SIZE_B64, led_tpg_pkg::SIZE_B128, led_tpg_pkg::SIZE_B256,
      led_tpg_pkg::SIZE_B512, led_tpg_pkg::SIZE_B1024, led_tpg_pkg::SIZE_B1518,
      led_tpg_pkg::SIZE_B9600, led_tpg_pkg::SIZE_B64};
    for (int i = 0; i < 8; i++) begin
      i_host.wr_reg(5'h1c, {4'h0, i[1:0], i[1:0], 1'b0, i[2:0], 4'h0});
      cyc(2);
      chk("gap", {2'h0, gx[i % 4]}, {2'h0, gap});
      chk("size", {2'h0, sx[i]}, {2'h0, size});
      chk("ptype", (i % 4 == 3) ? 16'h0000 : 16'(i % 4), {14'h0000, cfg.ptype});
    end
  endtask
  task automatic t_single();
    i_host.wr_reg(5'h1c, 16'h2003);
    wait_req(1'b1);
    chk("cfg", 16'h0380, {6'h00, cfg});
    pkt_done();
    cyc(3);
    chk("req", 16'h0000, {15'h0000, req});
    chk("busy", 16'h0001, {15'h0000, busy});
    i_host.wr_reg(5'h1c, 16'h2001);
    cyc(3);
    chk("busy", 16'h0000, {15'h0000, busy});
    i_host.wr_reg(5'h1c, 16'h2003);
    wait_req(1'b1);
  endtask
  task automatic t_burst();
    i_host.wr_reg(5'h1c, 16'h0003);
    wait_req(1'b1);
    for (int i = 1; i <= 4; i++) begin
      pkt_done();
      chk("count", 16'(i % 4), {2'h0, cnt});
    end
    chk("req", 16'h0001, {15'h0000, req});
    // start still set: clearing the enable alone stops it
    i_host.wr_reg(5'h1c, 16'h0002);
    wait_req(1'b0);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    cyc(2);
    chk("led", 16'h0008, {12'h000, led});
    chk("busy", 16'h0000, {15'h0000, busy});
    rdchk(5'h1b, 16'h0f00);
    rdchk(5'h1c, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_reserved();
    t_led();
    t_fields();
    t_single();
    t_burst();
    wrap_up();
  end
endmodule // led_tpg_regs_bench

// ==== test/mgmt_host.sv ====
// management host model: register writes and reads over the internal register port
`timescale 1ns/10ps
module mgmt_host (
  // clock and read data
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  // register port drive
  output logic [4:0] addr_o,
  output logic wr_o,
  output logic [15:0] wdata_o,
  output logic rd_o
);
  initial begin
    addr_o = 5'h00;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
    rd_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one strobe per cycle, held until the sampling edge
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // released data lines show the inverse, not a stale copy
    wdata_o <= ~d;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask
endmodule // mgmt_host
